// *** core/sdf_regs.svh ***
// timing counts, field widths and reset values of the decimation filter
`ifndef SDF_REGS_SVH
`define SDF_REGS_SVH

`define SDF_RATIO_SEL_W 3
`define SDF_RATIO_SEL_RST 3'h3
`define SDF_MCLK_HZ 32'h0131_2D00
`define SDF_MOD_DIV 2
`define SDF_BASE_RATIO 15'h0080
`define SDF_SINC3_MAX_MASK 10'h03FF
`define SDF_FAST_SAMPLES 2'h2
`define SDF_FAST_SHIFT_BASE 5'h17
`define SDF_SINC3_SHIFT_BASE 4'h9
`define SDF_SINC3_SHIFT_STEP 4'h3
`define SDF_SETTLE_128 16'h01B0
`define SDF_SETTLE_256 16'h0330
`define SDF_SETTLE_512 16'h0630
`define SDF_SETTLE_1024 16'h0C30
`define SDF_SETTLE_2048 16'h1830
`define SDF_SETTLE_4096 16'h2830
`define SDF_SETTLE_8192 16'h4830
`define SDF_SETTLE_16384 16'h8830

`endif

// *** core/sdf_pkg.sv ***
// types shared by the decimation filter files
package sdf_pkg;

	typedef enum logic [1:0] {
		SDF_PATH_FAST = 2'b01,
		SDF_PATH_SINC3 = 2'b10
	} sdf_path_e;

	typedef logic [31:0] sdf_word_t;

endpackage : sdf_pkg

// *** core/sdf_buf2.sv ***
// small valid/ready buffer between the filter and the sample readout
`timescale 1ns/1ps
module sdf_buf2 #(
	parameter int W = 32,
	parameter int DEPTH = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic push;
	logic pop;

	assign in_ready_o = (count != CW'(DEPTH));
	assign out_valid_o = (count != '0);
	assign out_data_o = mem[rd_ptr];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr + 1'b1);
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr + 1'b1);
			end
			if (push && !pop) begin
				count <= CW'(count + 1'b1);
			end else if (pop && !push) begin
				count <= CW'(count - 1'b1);
			end
		end
	end

endmodule : sdf_buf2

// *** core/sdf_decim.sv ***
// decimation filter: fast-settling sinc1 start-up path, sinc3 and sinc3 + sinc1 paths
//
// Contract
// - averaging linear-phase sinc low-pass filter
// - one output per ratio modulator samples
// - three-bit select offers eight ratios
// - bitstream feeds sinc3 and fast paths together
// - first samples after reset from fast path
// - after two samples switch to sinc3, stay
// - ratios 128 to 1024: sinc3 full ratio
// - ratios 2048 up: sinc3 at 1024, sinc1 follows
// - trailing sinc1 decimates by ratio over 1024
// - nulls at multiples of output rate
// - restart settling on enable, mux, gain, resync
// - settling times per ratio as tabulated
// - unsettled samples still output, not flagged
// - first ready falling edge after settling settled
// - modulator clock is half main clock
`timescale 1ns/1ps
`include "sdf_regs.svh"
module sdf_decim
	import sdf_pkg::*;
#(
	parameter int BUF_DEPTH = 2
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// modulator side
	input wire logic mod_bit_i,
	output logic mod_ready_o,
	// configuration
	input wire logic [`SDF_RATIO_SEL_W-1:0] decimation_ratio_select_i,
	input wire logic restart_i,
	// sample readout
	input wire logic sample_accept_i,
	output sdf_word_t sample_o,
	output logic sample_valid_o,
	output logic sample_ready_n_o,
	output logic [15:0] settle_time_o
);

	////////////////////////////////////////////////////////////////////////////
	// modulator rate enable and start-up

	logic mod_phase;
	logic armed;
	logic clear;
	logic step;
	logic buf_in_ready;

	// half of the main clock; stalls while the output buffer is full and while clear is high (a restart or the first clock after reset)
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mod_phase <= 1'b0;
		end else begin
			mod_phase <= ~mod_phase;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			armed <= 1'b0;
		end else begin
			armed <= 1'b1;
		end
	end

	assign clear = restart_i || !armed;
	assign step = mod_phase && buf_in_ready && !clear;

	////////////////////////////////////////////////////////////////////////////
	// ratio selection

	logic [`SDF_RATIO_SEL_W-1:0] ratio_sel;
	logic big_ratio;
	logic [13:0] ovr_mask;
	logic [9:0] s3_mask;
	logic [4:0] fast_shift;
	logic [3:0] s3_shift;
	logic [2:0] tail_shift;

	// latched only at a restart or on the first clock after reset, so a mid-run change cannot tear a period
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ratio_sel <= `SDF_RATIO_SEL_RST;
		end else if (clear) begin
			ratio_sel <= decimation_ratio_select_i;
		end
	end

	assign big_ratio = ratio_sel[2];
	assign ovr_mask = 14'((`SDF_BASE_RATIO << ratio_sel) - 15'h0001);
	assign s3_mask = big_ratio ? `SDF_SINC3_MAX_MASK : ovr_mask[9:0];
	assign fast_shift = 5'(`SDF_FAST_SHIFT_BASE - {2'h0, ratio_sel});
	assign s3_shift = big_ratio ? 4'h0
		: 4'(`SDF_SINC3_SHIFT_BASE - 4'({2'h0, ratio_sel[1:0]} * `SDF_SINC3_SHIFT_STEP));
	assign tail_shift = big_ratio ? 3'({1'b0, ratio_sel[1:0]} + 3'h1) : 3'h0;

	// settling figure in modulator periods for the host to track
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			settle_time_o <= `SDF_SETTLE_1024;
		end else begin
			unique case (ratio_sel)
				3'h0: settle_time_o <= `SDF_SETTLE_128;
				3'h1: settle_time_o <= `SDF_SETTLE_256;
				3'h2: settle_time_o <= `SDF_SETTLE_512;
				3'h3: settle_time_o <= `SDF_SETTLE_1024;
				3'h4: settle_time_o <= `SDF_SETTLE_2048;
				3'h5: settle_time_o <= `SDF_SETTLE_4096;
				3'h6: settle_time_o <= `SDF_SETTLE_8192;
				3'h7: settle_time_o <= `SDF_SETTLE_16384;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// decimation phase

	logic [13:0] ovr_cnt;
	logic ovr_end;
	logic s3_strobe;

	// one counter paces all paths so their outputs share a boundary
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ovr_cnt <= 14'h0000;
		end else if (clear) begin
			ovr_cnt <= 14'h0000;
		end else if (step) begin
			ovr_cnt <= (ovr_cnt == ovr_mask) ? 14'h0000 : 14'(ovr_cnt + 14'h0001);
		end
	end

	assign ovr_end = step && (ovr_cnt == ovr_mask);
	assign s3_strobe = step && ((ovr_cnt[9:0] & s3_mask) == s3_mask);

	////////////////////////////////////////////////////////////////////////////
	// sinc3 integrators at the modulator rate

	logic [31:0] integ1;
	logic [31:0] integ2;
	logic [31:0] integ3;

	// wrap-around is harmless: the combs recover the exact difference
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			integ1 <= 32'h0000_0000;
			integ2 <= 32'h0000_0000;
			integ3 <= 32'h0000_0000;
		end else if (clear) begin
			integ1 <= 32'h0000_0000;
			integ2 <= 32'h0000_0000;
			integ3 <= 32'h0000_0000;
		end else if (step) begin
			integ1 <= 32'(integ1 + {31'h0, mod_bit_i});
			integ2 <= 32'(integ2 + integ1);
			integ3 <= 32'(integ3 + integ2);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sinc3 combs at the sinc3 output rate

	logic [31:0] comb_d1;
	logic [31:0] comb_d2;
	logic [31:0] comb_d3;
	logic [31:0] comb1;
	logic [31:0] comb2;
	logic [31:0] comb3;

	assign comb1 = 32'(integ3 - comb_d1);
	assign comb2 = 32'(comb1 - comb_d2);
	assign comb3 = 32'(comb2 - comb_d3);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			comb_d1 <= 32'h0000_0000;
			comb_d2 <= 32'h0000_0000;
			comb_d3 <= 32'h0000_0000;
		end else if (clear) begin
			comb_d1 <= 32'h0000_0000;
			comb_d2 <= 32'h0000_0000;
			comb_d3 <= 32'h0000_0000;
		end else if (s3_strobe) begin
			comb_d1 <= integ3;
			comb_d2 <= comb1;
			comb_d3 <= comb2;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// trailing sinc1 for the high ratios

	logic [35:0] tail_acc;
	logic [35:0] tail_sum;

	assign tail_sum = 36'(tail_acc + {4'h0, comb3});

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tail_acc <= 36'h0_0000_0000;
		end else if (clear || ovr_end) begin
			tail_acc <= 36'h0_0000_0000;
		end else if (s3_strobe && big_ratio) begin
			tail_acc <= tail_sum;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fast-settling sinc1 path

	logic [14:0] fast_acc;
	logic [14:0] fast_sum;

	assign fast_sum = 15'(fast_acc + {14'h0000, mod_bit_i});

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fast_acc <= 15'h0000;
		end else if (clear || ovr_end) begin
			fast_acc <= 15'h0000;
		end else if (step) begin
			fast_acc <= fast_sum;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// path selection

	sdf_path_e path;
	logic [1:0] fast_cnt;

	// only a device reset returns to the fast path; a restart just resettles
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			path <= SDF_PATH_FAST;
			fast_cnt <= 2'h0;
		end else if (ovr_end) begin
			unique case (path)
				SDF_PATH_FAST: begin
					fast_cnt <= 2'(fast_cnt + 2'h1);
					if (2'(fast_cnt + 2'h1) == `SDF_FAST_SAMPLES) begin
						path <= SDF_PATH_SINC3;
					end
				end
				SDF_PATH_SINC3: begin
					path <= SDF_PATH_SINC3;
				end
				// an upset code falls back to the settled path
				default: begin
					path <= SDF_PATH_SINC3;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// normalisation to a common full scale of 2^30

	sdf_word_t fast_word;
	sdf_word_t s3_word;
	sdf_word_t tail_word;
	sdf_word_t filt_word;
	logic [35:0] tail_shifted;

	assign fast_word = 32'({17'h0_0000, fast_sum} << fast_shift);
	assign s3_word = 32'(comb3 << s3_shift);
	assign tail_shifted = tail_sum >> tail_shift;
	assign tail_word = tail_shifted[31:0];

	always_comb begin
		if (path == SDF_PATH_FAST) begin
			filt_word = fast_word;
		end else if (big_ratio) begin
			filt_word = tail_word;
		end else begin
			filt_word = s3_word;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output buffer and readout

	logic buf_out_valid;
	sdf_word_t buf_out_data;
	logic pop;
	logic take;

	// one word every other cycle at most, so each word gets its own falling edge on the ready line
	assign take = sample_accept_i && !sample_valid_o;

	// a full buffer halts the modulator rate so no word is dropped
	sdf_buf2 #(
		.W(32),
		.DEPTH(BUF_DEPTH)
	) u_buf (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(ovr_end),
		.in_ready_o(buf_in_ready),
		.in_data_i(filt_word),
		.out_valid_o(buf_out_valid),
		.out_ready_i(take),
		.out_data_o(buf_out_data)
	);

	assign pop = buf_out_valid && take;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mod_ready_o <= 1'b0;
		end else begin
			mod_ready_o <= buf_in_ready;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_o <= 32'h0000_0000;
		end else if (pop) begin
			sample_o <= buf_out_data;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_valid_o <= 1'b0;
		end else begin
			sample_valid_o <= pop;
		end
	end

	// the ready line idles high and falls once per word
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sample_ready_n_o <= 1'b1;
		end else begin
			sample_ready_n_o <= ~pop;
		end
	end

endmodule : sdf_decim

// *** verif/sdf_decim_checker.sv ***
// port-level assertions for the decimation filter
`timescale 1ns/1ps
module sdf_decim_checker
	import sdf_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// modulator and configuration
	input wire logic mod_bit_i,
	input wire logic mod_ready_o,
	input wire logic [2:0] decimation_ratio_select_i,
	input wire logic restart_i,
	// readout
	input wire logic sample_accept_i,
	input wire sdf_word_t sample_o,
	input wire logic sample_valid_o,
	input wire logic sample_ready_n_o,
	input wire logic [15:0] settle_time_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////
	sequence two_s;
		sample_valid_o ##1 sample_valid_o;
	endsequence
	sequence new_s(logic [2:0] c);
		restart_i && decimation_ratio_select_i == c;
	endsequence
	strobe_low_a: assert property (sample_valid_o |-> !sample_ready_n_o)
		else $error("ready line high during strobe");
	idle_high_a: assert property (!sample_valid_o |-> sample_ready_n_o)
		else $error("ready line low without strobe");
	word_hold_a: assert property (!sample_valid_o |-> $stable(sample_o))
		else $error("word changed without strobe");
	strobe_cause_a: assert property (sample_valid_o |-> $past(sample_accept_i))
		else $error("strobe without accept");
	burst_cap_a: assert property (not two_s)
		else $error("strobes in two cycles in a row");
	settle_min_a: assert property (new_s(3'h0) |-> ##[1:2] settle_time_o == 16'h01B0)
		else $error("wrong settling time for code 0");
	settle_mid_a: assert property (new_s(3'h4) |-> ##[1:2] settle_time_o == 16'h1830)
		else $error("wrong settling time for code 4");
	settle_max_a: assert property (new_s(3'h7) |-> ##[1:2] settle_time_o == 16'h8830)
		else $error("wrong settling time for code 7");
	reset_out_a: assert property ($rose(rst_n_i) |-> settle_time_o == 16'h0C30 && sample_ready_n_o)
		else $error("wrong values at reset release");
endmodule : sdf_decim_checker

// *** verif/sdf_mod_model.sv ***
// behavioural modulator giving a constant ones density
`timescale 1ns/1ps
module sdf_mod_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// density and bitstream
	input wire logic level_i,
	output logic mod_bit_o
);
	// a real modulator never pauses, so the bit follows the level every clock
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			mod_bit_o <= 1'b0;
		else
			mod_bit_o <= level_i;
	end
endmodule : sdf_mod_model

// *** verif/tb_top.sv ***
// self-checking bench for the decimation filter
`timescale 1ns/1ps
module tb_top;
	import sdf_pkg::*;
	logic clk_i = 0;
	logic rst_n_i = 0;
	logic restart_i = 0;
	logic sample_accept_i = 0;
	logic level = 1;
	logic stall = 0;
	logic [2:0] sel = 3'h0;
	logic mod_bit_i;
	logic mod_ready_o;
	logic sample_valid_o;
	logic sample_ready_n_o;
	sdf_word_t sample_o;
	logic [15:0] settle_time_o;
	logic [32:0] e;
	logic [32:0] exp_q[$];
	int error_cnt = 0;
	int checks_done = 0;
	logic [15:0] tab [8] = '{16'h01B0, 16'h0330, 16'h0630, 16'h0C30, 16'h1830, 16'h2830, 16'h4830, 16'h8830};
	always #25 clk_i = ~clk_i;
	sdf_decim i_dut (.clk_i, .rst_n_i, .mod_bit_i, .mod_ready_o, .decimation_ratio_select_i(sel), .restart_i,
		.sample_accept_i, .sample_o, .sample_valid_o, .sample_ready_n_o, .settle_time_o);
	sdf_mod_model i_mod (.clk_i, .rst_n_i, .level_i(level), .mod_bit_o(mod_bit_i));
	////////////////////////////////////////
	task automatic end_sim();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : end_sim
	task automatic cmp(input logic [31:0] got, input logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask : cmp
	task automatic cmp_word(input sdf_word_t got, input sdf_word_t want);
		cmp(got, want);
	endtask : cmp_word
	task automatic cmp_ready(input logic got, input logic want);
		cmp({31'h0, got}, {31'h0, want});
	endtask : cmp_ready
	task automatic cmp_settle(input logic [15:0] got, input logic [15:0] want);
		cmp({16'h0, got}, {16'h0, want});
	endtask : cmp_settle
	task automatic ticks(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : ticks
	// full scale is 2^30 for an all-ones stream, 0 for all zeros
	task automatic note(input int skip, input int chk);
		for (int i = 0; i < skip + chk; i++)
			exp_q.push_back({i >= skip, level ? 32'h4000_0000 : 32'h0});
	endtask : note
	// words before the first one past settling are unsettled, plus up to two old ones in flight
	task automatic restart(input logic [2:0] n, input logic lv);
		int k;
		sel = n;
		level = lv;
		restart_i = 1;
		ticks(1);
		restart_i = 0;
		k = (tab[n] + (128 << n) - 1) / (128 << n);
		note(k + 2, 2);
	endtask : restart
	task automatic drain();
		for (int t = 0; t < 40000 && exp_q.size() > 0; t++)
			ticks(1);
		if (exp_q.size() > 0) begin
			error_cnt++;
			end_sim();
		end
	endtask : drain
	////////////////////////////////////////
	always @(posedge clk_i) begin
		#2;
		if (sample_valid_o === 1'b1 && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e[32])
				cmp_word(sample_o, e[31:0]);
		end
	end
	initial begin
		void'($urandom(32'haff4_0c2b));
		fork
			forever begin
				@(posedge clk_i);
				sample_accept_i <= #1 !stall && ($urandom_range(3) != 0);
			end
		join_none
		note(0, 2);
		exp_q.push_back(33'h0);
		note(0, 2);
		ticks(20);
		rst_n_i = 1;
		stall = 1;
		ticks(1500);
		cmp_ready(mod_ready_o, 1'b0);
		stall = 0;
		drain();
		for (int c = 0; c < 8; c++) begin
			restart(c[2:0], 1);
			ticks(3);
			cmp_settle(settle_time_o, tab[c]);
			exp_q.delete();
		end
		restart(3'h0, 0);
		drain();
		restart(3'h3, 1);
		drain();
		restart(3'h4, 1);
		drain();
		end_sim();
	end
endmodule : tb_top
bind sdf_decim sdf_decim_checker i_chk (.clk_i, .rst_n_i, .mod_bit_i, .mod_ready_o, .decimation_ratio_select_i,
	.restart_i, .sample_accept_i, .sample_o, .sample_valid_o, .sample_ready_n_o, .settle_time_o);
